// ---- verilog/pwd_pkg.sv ----
// shared constants of the protected watchdog timer
package pwd_pkg;

  // ************************************************************
  // register map (byte addresses on apb)
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COUNTER        = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_MODE     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h10;

  // ************************************************************
  // control/status field positions
  // ************************************************************
  localparam int BIT_COUNTER_WE_INHIBIT = 7;
  localparam int BIT_COUNTER_WE         = 6;
  localparam int BIT_REG_WE_INHIBIT     = 5;
  localparam int BIT_REG_WE             = 4;
  localparam int BIT_RUN_INHIBIT        = 3;
  localparam int BIT_RUN                = 2;
  localparam int BIT_CAUSE_INHIBIT      = 1;
  localparam int BIT_CAUSE              = 0;

  // ************************************************************
  // widths, reset values, counts
  // ************************************************************
  localparam int          CNT_W          = 8;
  localparam logic [7:0]  CNT_MAX        = 8'hFF;
  localparam logic [7:0]  CNT_RESET      = 8'h00;
  localparam logic [3:0]  MODE_RESET     = 4'hF;
  localparam logic [3:0]  MODE_PAD_ONES  = 4'hF;
  localparam int          PRESCALE_W     = 13;
  localparam int          TAP_COUNT      = 8;
  localparam int          TAP_FIRST_LOG2 = 6;
  localparam int          RST_OSC_CYCLES = 256;
  localparam logic [7:0]  RST_LEFT_INIT  = 8'(RST_OSC_CYCLES - 1);
  localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

endpackage : pwd_pkg

// ---- verilog/pwd_prescaler.sv ----
// free-running prescaler producing the eight divided-clock enable pulses
`timescale 1ns/1ps
module pwd_prescaler #(
  parameter int DIV_W  = pwd_pkg::PRESCALE_W,
  parameter int TAPS   = pwd_pkg::TAP_COUNT,
  parameter int FIRST  = pwd_pkg::TAP_FIRST_LOG2
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            nrst,
  // one-cycle pulses, tap k at clock / 2^(FIRST+k)
  output logic [TAPS-1:0]      tap_tick
);

  logic [DIV_W-1:0] div_cnt;

  // ************************************************************
  // divider chain
  // ************************************************************
  // single counter serves all taps so their pulses stay aligned
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + DIV_W'(1);
  end

  // one pulse per tap when its low bits are all ones
  genvar k;
  generate
    for (k = 0; k < TAPS; k++)
    begin : g_tap
      localparam logic [DIV_W-1:0] MASK = DIV_W'((1 << (FIRST + k)) - 1);
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          tap_tick[k] <= 1'b0;
        else
          tap_tick[k] <= ((div_cnt & MASK) == MASK);
      end
    end
  endgenerate

endmodule : pwd_prescaler

// ---- verilog/pwd_watchdog.sv ----
// protected watchdog timer with guarded control register and apb slave
`timescale 1ns/1ps
module pwd_watchdog #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // internal oscillator, asynchronous to core_clk
  input  wire logic              osc_clk_in,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // outputs to the chip
  output logic                   wdt_reset_out,
  output logic                   irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic                              counter_write_enable;
  logic                              register_write_enable;
  logic                              run_bit;
  logic                              reset_cause_flag;
  logic [pwd_pkg::CNT_W-1:0]         wdt_counter;
  logic [3:0]                        clock_select_field;
  logic                              irq_status;
  logic                              irq_mask;
  logic [7:0]                        rst_left;
  logic                              osc_s1;
  logic                              osc_s2;
  logic                              osc_s3;
  logic                              osc_tick;
  logic [pwd_pkg::TAP_COUNT-1:0]     tap_tick;
  logic                              count_tick;
  logic                              access;
  logic                              wr_now;
  logic                              cnt_load;
  logic                              overflow;
  logic [31:0]                       next_prdata;
  logic                              next_err;

  // ************************************************************
  // count sources
  // ************************************************************
  pwd_prescaler #(
    .DIV_W (pwd_pkg::PRESCALE_W),
    .TAPS  (pwd_pkg::TAP_COUNT),
    .FIRST (pwd_pkg::TAP_FIRST_LOG2)
  ) u_prescaler (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tap_tick (tap_tick)
  );

  // oscillator synchroniser; edges seen only on stage two and three
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end
    else
    begin
      osc_s1 <= osc_clk_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // oscillator must run slower than core_clk / 2 to be seen at all
  assign osc_tick = osc_s2 & ~osc_s3;

  // source decode, shared by the counter and its checks
  function automatic logic pick_tick(input logic [3:0]                    sel,
                                     input logic [pwd_pkg::TAP_COUNT-1:0] taps,
                                     input logic                          osc);
    if (sel[3])
      pick_tick = taps[sel[2:0]];
    else
      pick_tick = osc;
  endfunction : pick_tick

  // oscillator path has no gating by chip mode; like the taps it counts only while run_bit is set
  assign count_tick = pick_tick(clock_select_field, tap_tick, osc_tick);

  // ************************************************************
  // apb decode
  // ************************************************************
  // one wait state so that pready and prdata come from flops
  assign access   = psel & penable;
  assign wr_now   = access & pready & pwrite;
  assign cnt_load = wr_now & (paddr == ADDR_W'(pwd_pkg::ADDR_COUNTER)) & counter_write_enable;
  assign overflow = run_bit & count_tick & ~cnt_load & (wdt_counter == pwd_pkg::CNT_MAX);

  // read mux and error decode
  always_comb
  begin
    next_prdata = pwd_pkg::DATA_ZERO;
    next_err    = 1'b0;
    if (paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS))
      next_prdata[7:0] = {1'b1, counter_write_enable, 1'b1, register_write_enable,
                          1'b1, run_bit, 1'b1, reset_cause_flag};
    else if (paddr == ADDR_W'(pwd_pkg::ADDR_COUNTER))
      next_prdata[7:0] = wdt_counter;
    else if (paddr == ADDR_W'(pwd_pkg::ADDR_CLOCK_MODE))
      next_prdata[7:0] = {pwd_pkg::MODE_PAD_ONES, clock_select_field};
    else if (paddr == ADDR_W'(pwd_pkg::ADDR_IRQ_STATUS))
      next_prdata[0] = irq_status;
    else if (paddr == ADDR_W'(pwd_pkg::ADDR_IRQ_MASK))
      next_prdata[0] = irq_mask;
    else
      next_err = 1'b1;
  end

  // bus answer registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= pwd_pkg::DATA_ZERO;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & next_err;
      if (access & ~pready & ~pwrite)
        prdata <= next_prdata;
    end
  end

  // ************************************************************
  // control/status register
  // ************************************************************
  // each guarded bit looks only at its own inhibit in the same byte;
  // the run/cause guard uses the enable held before this write
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      counter_write_enable  <= 1'b0;
      register_write_enable <= 1'b0;
      run_bit               <= 1'b0;
    end
    else if (wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS))
    begin
      if (!pwdata[pwd_pkg::BIT_COUNTER_WE_INHIBIT])
        counter_write_enable <= pwdata[pwd_pkg::BIT_COUNTER_WE];
      if (!pwdata[pwd_pkg::BIT_REG_WE_INHIBIT])
        register_write_enable <= pwdata[pwd_pkg::BIT_REG_WE];
      if (register_write_enable && !pwdata[pwd_pkg::BIT_RUN_INHIBIT])
        run_bit <= pwdata[pwd_pkg::BIT_RUN];
    end
  end

  // cause flag; only overflow sets it, software may only clear it; set wins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reset_cause_flag <= 1'b0;
    else if (overflow)
      reset_cause_flag <= 1'b1;
    else if (wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && register_write_enable &&
             !pwdata[pwd_pkg::BIT_CAUSE_INHIBIT] && !pwdata[pwd_pkg::BIT_CAUSE])
      reset_cause_flag <= 1'b0;
  end

  // ************************************************************
  // counter and clock mode
  // ************************************************************
  // a load beats a same-cycle count pulse
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      wdt_counter <= pwd_pkg::CNT_RESET;
    else if (cnt_load)
      wdt_counter <= pwdata[pwd_pkg::CNT_W-1:0];
    else if (run_bit && count_tick)
      wdt_counter <= wdt_counter + pwd_pkg::CNT_W'(1);
  end

  // clock select; switching may add one stray pulse
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      clock_select_field <= pwd_pkg::MODE_RESET;
    else if (wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CLOCK_MODE))
      clock_select_field <= pwdata[3:0];
  end

  // ************************************************************
  // internal reset pulse
  // ************************************************************
  // stretched in oscillator periods; a new overflow restarts it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wdt_reset_out <= 1'b0;
      rst_left      <= '0;
    end
    else if (overflow)
    begin
      wdt_reset_out <= 1'b1;
      rst_left      <= pwd_pkg::RST_LEFT_INIT;
    end
    else if (wdt_reset_out && osc_tick)
    begin
      if (rst_left == '0)
        wdt_reset_out <= 1'b0;
      else
        rst_left <= rst_left - 8'(1);
    end
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  // overflow sets status, write one clears; set wins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_status <= 1'b0;
      irq_mask   <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      if (overflow)
        irq_status <= 1'b1;
      else if (wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_IRQ_STATUS) && pwdata[0])
        irq_status <= 1'b0;
      if (wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_IRQ_MASK))
        irq_mask <= pwdata[0];
      irq <= irq_status & irq_mask;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_inhibit_ones_read: assert property (
    access && !pready && !pwrite && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS)
    |=> pready && prdata[7] && prdata[5] && prdata[3] && prdata[1])
    else $error("inhibit bits did not read as one");

  chk_counter_guard: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_COUNTER) && !counter_write_enable && !(run_bit && count_tick)
    |=> $stable(wdt_counter))
    else $error("counter changed on a disabled write");

  chk_counter_load: assert property (
    cnt_load |=> wdt_counter == $past(pwdata[7:0]))
    else $error("counter did not take the loaded value");

  chk_run_halt: assert property (
    !run_bit && !cnt_load |=> $stable(wdt_counter))
    else $error("counter moved while halted");

  chk_cwe_inhibit: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && pwdata[7]
    |=> $stable(counter_write_enable))
    else $error("counter write enable changed under inhibit");

  chk_rwe_inhibit: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && pwdata[5]
    |=> $stable(register_write_enable))
    else $error("register write enable changed under inhibit");

  chk_run_guard: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && (!register_write_enable || pwdata[3])
    |=> $stable(run_bit))
    else $error("run bit changed without its guards");

  chk_overflow_reset: assert property (
    overflow |=> wdt_reset_out && reset_cause_flag && wdt_counter == pwd_pkg::CNT_RESET
                 && rst_left == pwd_pkg::RST_LEFT_INIT)
    else $error("overflow did not raise reset and cause");

  chk_reset_length: assert property (
    $fell(wdt_reset_out) |-> $past(rst_left) == '0 && $past(osc_tick))
    else $error("internal reset ended early");

  chk_cause_clear_guard: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && pwdata[1] && !overflow
    |=> $stable(reset_cause_flag))
    else $error("cause flag changed under inhibit");

  chk_cause_hw_set: assert property (
    !overflow |=> !$rose(reset_cause_flag))
    else $error("cause flag set without an overflow");

  chk_cause_sw_clear: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && register_write_enable
    && !pwdata[1] && !pwdata[0] && !overflow
    |=> !reset_cause_flag)
    else $error("guarded write did not clear the cause flag");

  chk_run_guarded_write: assert property (
    wr_now && paddr == ADDR_W'(pwd_pkg::ADDR_CONTROL_STATUS) && register_write_enable && !pwdata[3]
    |=> run_bit == $past(pwdata[2]))
    else $error("run bit did not follow a guarded write");

  chk_osc_count: assert property (
    run_bit && !clock_select_field[3] && osc_tick && !cnt_load && wdt_counter != pwd_pkg::CNT_MAX
    |=> wdt_counter == $past(wdt_counter) + pwd_pkg::CNT_W'(1))
    else $error("counter missed an oscillator tick");

endmodule : pwd_watchdog

// ---- tb/tb_pwd_watchdog.sv ----
// self-checking testbench for the protected watchdog timer
`timescale 1ns/1ps
module tb_pwd_watchdog;
  // ************************************************************
  // signals
  // ************************************************************
  logic        core_clk;
  logic        nrst;
  logic        osc_clk_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        wdt_reset_out;
  logic        irq;
  int          bad_count = 0;
  int          checked   = 0;
  logic [31:0] rd;
  logic        err;

  pwd_watchdog #(.ADDR_W(8)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .osc_clk_in(osc_clk_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wdt_reset_out(wdt_reset_out), .irq(irq)
  );

  // 40 mhz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // oscillator at a quarter of the core rate, phase unrelated
  initial
  begin
    osc_clk_in = 1'b0;
    #7;
    forever #50 osc_clk_in = ~osc_clk_in;
  end

  // ************************************************************
  // compare and bus tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_range

  // one apb transfer; pready, prdata and pslverr are read at the rising edge
  // that ends the access, before the design's own updates of that edge land
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      bad_count++;
      $display("Error pready expected 1 seen timeout");
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}); // whole-byte writes only
  endtask : wr

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(name, {24'h000000, exp}, rd);
  endtask : rdchk

  // counts cycles while the reset request equals lvl
  task automatic wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (wdt_reset_out === lvl && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_lvl

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hAA);
    rdchk("counter", pwd_pkg::ADDR_COUNTER, 8'h00);
    rdchk("mode", pwd_pkg::ADDR_CLOCK_MODE, 8'hFF);
    rdchk("irq_status", pwd_pkg::ADDR_IRQ_STATUS, 8'h00);
    rdchk("irq_mask", pwd_pkg::ADDR_IRQ_MASK, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_guard;
    wr(pwd_pkg::ADDR_COUNTER, 8'h33);
    rdchk("counter", pwd_pkg::ADDR_COUNTER, 8'h00);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hC0);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hAA);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'h40);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hEA);
    wr(pwd_pkg::ADDR_COUNTER, 8'h55);
    rdchk("counter", pwd_pkg::ADDR_COUNTER, 8'h55);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'h64);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hEA);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'h50);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFA);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hFD);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFA);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hFC);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFA);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hF6);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFE);
    apb(1'b1, 8'h20, 32'h000000FF);
    chk("wr_slverr", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0);
    chk("rd_slverr", 32'h1, {31'h0, err});
    chk("rd_unmapped", 32'h0, rd);
    $display("test guard done");
  endtask : t_guard

  // every tap code, preset one below full so two ticks reach overflow
  task automatic t_taps;
    int n;
    int p;
    wr(pwd_pkg::ADDR_IRQ_MASK, 8'h01);
    for (int k = 0; k < 8; k++)
    begin
      p = 64 << k;
      wr(pwd_pkg::ADDR_CLOCK_MODE, 8'(8 + k));
      wr(pwd_pkg::ADDR_COUNTER, 8'hFE);
      wait_lvl(1'b0, 2 * p + 20, n);
      chk_range("overflow_time", p, 2 * p + 4, n);
      wait_lvl(1'b1, 1200, n);
      chk_range("reset_width", 1016, 1032, n);
      rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFF);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk("irq_status", pwd_pkg::ADDR_IRQ_STATUS, 8'h01);
      wr(pwd_pkg::ADDR_IRQ_STATUS, 8'h01);
      @(posedge core_clk);
      @(negedge core_clk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hF8);
      rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFE);
    end
    $display("test taps done");
  endtask : t_taps

  task automatic t_osc;
    int n;
    logic [7:0] v;
    wr(pwd_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(pwd_pkg::ADDR_CLOCK_MODE, 8'h05);
    wr(pwd_pkg::ADDR_COUNTER, 8'hFE);
    wait_lvl(1'b0, 40, n);
    chk_range("osc_overflow", 4, 16, n);
    @(negedge core_clk);
    @(negedge core_clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("irq_status", pwd_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(pwd_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(pwd_pkg::ADDR_CONTROL_STATUS, 8'hF2);
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hFB);
    apb(1'b0, pwd_pkg::ADDR_COUNTER, 32'h0);
    v = rd[7:0];
    repeat (100) @(posedge core_clk);
    rdchk("counter_halt", pwd_pkg::ADDR_COUNTER, v);
    $display("test osc done");
  endtask : t_osc

  // pin reset with the counter already halted clears both write enables and cause
  task automatic t_pin;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdchk("ctrl", pwd_pkg::ADDR_CONTROL_STATUS, 8'hAA);
    rdchk("counter", pwd_pkg::ADDR_COUNTER, 8'h00);
    $display("test pin done");
  endtask : t_pin

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_guard();
    t_taps();
    t_osc();
    t_pin();
    end_of_test();
  end

  // taps need about 34k cycles, so this limit leaves margin
  initial
  begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
endmodule : tb_pwd_watchdog
